// [rh_regs_pkg.sv]
package rh_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_MASK_REMOVABLE = 8'h4c;  // Port mask and removable flags
    localparam logic [7:0]  OFS_HUB_STATUS     = 8'h50;  // Hub status and change

    // ------------------------------------------------------------
    // Field positions in the hub status and descriptor words
    // ------------------------------------------------------------
    localparam int BIT_CLR_WAKE   = 31;  // Clear wake enable command
    localparam int BIT_OC_CHANGE  = 17;  // Overcurrent change flag
    localparam int BIT_SET_GPWR   = 16;  // Set global power command
    localparam int BIT_WAKE_EN    = 15;  // Wake on connect enable
    localparam int BIT_OC_IND     = 1;   // Overcurrent indicator
    localparam int BIT_CLR_GPWR   = 0;   // Clear global power command
    localparam int MASK_LSB       = 16;  // Port power mask low bit

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 2;                               // Downstream ports
    localparam logic [31:0] RST_MASK_REMOVABLE = 32'h0000_0000; // Descriptor reset
    localparam logic [15:0] PORT_FIELD_MASK    = 16'h0006;      // Bits 1..2 implemented

endpackage

// [port_power_ctl.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// One port's power enable under global commands
// ------------------------------------------------------------
module port_power_ctl
    import rh_regs_pkg::*;
(
    input  wire logic mclk,        // Clock
    input  wire logic arst_n,      // Async reset, active low
    input  wire logic perPortMode, // Power switching mode, 1 = per port
    input  wire logic maskBit,     // This port's power mask bit
    input  wire logic setGlobal,   // Set global power pulse
    input  wire logic clrGlobal,   // Clear global power pulse
    output logic      globalOn     // Power state from global commands
);

    logic onQ;   // Registered power state
    logic onD;   // Next power state
    logic obeys; // Port follows global commands

    // Next state from global commands
    always_comb
    begin
        obeys = !perPortMode || !maskBit;
        onD   = onQ;
        if (obeys && setGlobal)
        begin
            onD = 1'b1;
        end
        else if (obeys && clrGlobal)
        begin
            onD = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            onQ <= 1'b0;
        end
        else
        begin
            onQ <= onD;
        end
    end

    assign globalOn = onQ;

endmodule

`default_nettype wire

// [root_hub_power_status_regs.sv]
`timescale 1ns/1ps
`default_nettype none

module root_hub_power_status_regs
    import rh_regs_pkg::*;
(
    input  wire logic                 mclk,          // Bus clock
    input  wire logic                 arst_n,        // Async reset, active low
    input  wire logic [7:0]           regAddr,       // Offset from base address
    input  wire logic                 regWrite,      // Write strobe, one cycle
    input  wire logic                 regRead,       // Read strobe, one cycle
    input  wire logic [31:0]          regWdata,      // Write data
    output logic      [31:0]          regRdata,      // Read data, registered
    input  wire logic                 perPortMode,   // Power switching mode
    input  wire logic                 overcurrent,   // Overcurrent indicator in
    input  wire logic                 connectChange, // Connect change event
    input  wire logic                 suspended,     // Hub in suspend
    output logic                      resumeEvent,   // Wake request pulse
    output logic      [NUM_PORTS:1]   globalPowerOn, // Per port global power state
    output logic      [NUM_PORTS:1]   portPowerMask, // Effective mask per port
    output logic      [NUM_PORTS:1]   removableFlags // Removable flag per port
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0] descQ;      // Descriptor word
    logic [31:0] descD;      // Next descriptor word
    logic        ocChangeQ;  // Overcurrent change flag
    logic        ocChangeD;  // Next change flag
    logic        ocPrevQ;    // Last overcurrent level
    logic        wakeEnQ;    // Wake on connect enable
    logic        wakeEnD;    // Next wake enable
    logic [31:0] rdataD;     // Next read data
    logic        resumeQ;    // Registered resume pulse
    logic        resumeD;    // Next resume pulse
    logic        wrDesc;     // Descriptor write
    logic        wrStat;     // Status write
    logic        setGlobal;  // Set global power pulse
    logic        clrGlobal;  // Clear global power pulse

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wrDesc    = regWrite && (regAddr == OFS_MASK_REMOVABLE);
    assign wrStat    = regWrite && (regAddr == OFS_HUB_STATUS);
    assign setGlobal = wrStat && regWdata[BIT_SET_GPWR];
    assign clrGlobal = wrStat && regWdata[BIT_CLR_GPWR];

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb
    begin
        // Descriptor: only port bits stored, bit 0 reserved
        descD = descQ;
        if (wrDesc)
        begin
            descD = regWdata & {PORT_FIELD_MASK, PORT_FIELD_MASK};
        end
        // Change flag: hardware set beats write-one clear
        ocChangeD = ocChangeQ;
        if (wrStat && regWdata[BIT_OC_CHANGE])
        begin
            ocChangeD = 1'b0;
        end
        if (overcurrent != ocPrevQ)
        begin
            ocChangeD = 1'b1;
        end
        // Wake enable: set wins if both written
        wakeEnD = wakeEnQ;
        if (wrStat && regWdata[BIT_CLR_WAKE])
        begin
            wakeEnD = 1'b0;
        end
        if (wrStat && regWdata[BIT_WAKE_EN])
        begin
            wakeEnD = 1'b1;
        end
        // Connect change counts as resume in suspend with wake enabled
        resumeD = wakeEnQ && suspended && connectChange;
        // Read mux; commands read as zero
        rdataD = regRdata;
        if (regRead)
        begin
            rdataD = 32'h0000_0000;
            if (regAddr == OFS_MASK_REMOVABLE)
            begin
                rdataD = descQ;
            end
            else if (regAddr == OFS_HUB_STATUS)
            begin
                rdataD[BIT_OC_CHANGE] = ocChangeQ;
                rdataD[BIT_WAKE_EN]   = wakeEnQ;
                rdataD[BIT_OC_IND]    = ocPrevQ;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            descQ     <= RST_MASK_REMOVABLE;
            ocChangeQ <= 1'b0;
            ocPrevQ   <= 1'b0;
            wakeEnQ   <= 1'b0;
            resumeQ   <= 1'b0;
            regRdata  <= 32'h0000_0000;
        end
        else
        begin
            descQ     <= descD;
            ocChangeQ <= ocChangeD;
            ocPrevQ   <= overcurrent;
            wakeEnQ   <= wakeEnD;
            resumeQ   <= resumeD;
            regRdata  <= rdataD;
        end
    end

    assign resumeEvent = resumeQ;

    // ------------------------------------------------------------
    // Per-port power control
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 1; p <= NUM_PORTS; p++)
        begin : g_port
            port_power_ctl u_ctl (
                .mclk        (mclk),
                .arst_n      (arst_n),
                .perPortMode (perPortMode),
                .maskBit     (descQ[MASK_LSB + p]),
                .setGlobal   (setGlobal),
                .clrGlobal   (clrGlobal),
                .globalOn    (globalPowerOn[p])
            );
            assign portPowerMask[p]  = perPortMode && descQ[MASK_LSB + p];
            assign removableFlags[p] = descQ[p];
        end
    endgenerate

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_desc_write;
        @(posedge mclk) disable iff (!arst_n)
        wrDesc |=> descQ == ($past(regWdata) & 32'h0006_0006);
    endproperty
    a_desc_write: assert property (p_desc_write) else $error("descriptor store wrong");

    property p_oc_set;
        @(posedge mclk) disable iff (!arst_n)
        (overcurrent != ocPrevQ) |=> ocChangeQ;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("change flag not set");

    property p_oc_clear;
        @(posedge mclk) disable iff (!arst_n)
        (wrStat && regWdata[17] && overcurrent == ocPrevQ) |=> !ocChangeQ;
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("change flag not cleared");

    property p_oc_hold;
        @(posedge mclk) disable iff (!arst_n)
        (!(wrStat && regWdata[17]) && ocChangeQ) |=> ocChangeQ;
    endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("change flag lost");

    property p_wake_set;
        @(posedge mclk) disable iff (!arst_n)
        (wrStat && regWdata[15]) |=> wakeEnQ;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake enable not set");

    property p_wake_clr;
        @(posedge mclk) disable iff (!arst_n)
        (wrStat && regWdata[31] && !regWdata[15]) |=> !wakeEnQ;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake enable not cleared");

    property p_status_read;
        @(posedge mclk) disable iff (!arst_n)
        (regRead && regAddr == 8'h50) |=>
            (regRdata[31:18] == 14'h0 && regRdata[16] == 1'b0 && regRdata[0] == 1'b0);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status zeros wrong");

    property p_global_set;
        @(posedge mclk) disable iff (!arst_n)
        (setGlobal && !perPortMode) |=> (globalPowerOn == 2'b11);
    endproperty
    a_global_set: assert property (p_global_set) else $error("global set failed");

    property p_masked_hold;
        @(posedge mclk) disable iff (!arst_n)
        (perPortMode && descQ[17] && (setGlobal || clrGlobal)) |=>
            globalPowerOn[1] == $past(globalPowerOn[1]);
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("masked port changed");

    // Connect change in suspend with wake enabled gives a resume pulse
    property p_resume;
        @(posedge mclk) disable iff (!arst_n)
        (wakeEnQ && suspended && connectChange) |=> resumeEvent;
    endproperty
    a_resume: assert property (p_resume) else $error("resume not raised");

endmodule

`default_nettype wire

// [root_hub_power_status_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module root_hub_power_status_regs_tb;
    import rh_regs_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              mclk = 1'b0;      // Bus clock
    logic              arst_n = 1'b0;    // Reset, active low
    logic [7:0]        regAddr = 8'h00;  // Register offset
    logic              regWrite = 1'b0;  // Write strobe
    logic              regRead = 1'b0;   // Read strobe
    logic [31:0]       regWdata = 32'h0; // Write data
    logic [31:0]       regRdata;         // Read data
    logic              perPortMode = 1'b0;   // Switching mode
    logic              overcurrent = 1'b0;   // Overcurrent level
    logic              connectChange = 1'b0; // Connect change
    logic              suspended = 1'b0;     // Suspend level
    logic              resumeEvent;      // Wake pulse
    logic [NUM_PORTS:1] globalPowerOn;   // Global power state
    logic [NUM_PORTS:1] portPowerMask;   // Effective mask
    logic [NUM_PORTS:1] removableFlags;  // Removable flags
    logic [31:0]       expQ[$];          // Expected read data
    logic              rdFlag = 1'b0;    // Read taken last edge
    logic [31:0]       rnd;              // Random descriptor value
    int                err_count = 0;    // Mismatches
    int                cmp_count = 0;    // Comparisons

    always #5 mclk = ~mclk;

    root_hub_power_status_regs root_hub_power_status_regs_inst (
        .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .perPortMode(perPortMode), .overcurrent(overcurrent),
        .connectChange(connectChange), .suspended(suspended),
        .resumeEvent(resumeEvent), .globalPowerOn(globalPowerOn),
        .portPowerMask(portPowerMask), .removableFlags(removableFlags));

    // ------------------------------------------------------------
    // Check and close helpers
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus tasks, one strobe cycle each
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk); #1;
        regAddr = a; regWdata = d; regWrite = 1'b1;
        @(posedge mclk); #1;
        regWrite = 1'b0; regWdata = 32'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk); #1;
        expQ.push_back(e);
        regAddr = a; regRead = 1'b1;
        @(posedge mclk); #1;
        regRead = 1'b0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Read monitor: data settled by the falling edge after the read
    // ------------------------------------------------------------
    always @(posedge mclk) rdFlag <= regRead & arst_n;

    always @(negedge mclk)
    begin
        if (rdFlag)
        begin
            if (expQ.size() == 0)
                chk("read queue", 32'h1, 32'h0);
            else
                chk("regRdata", regRdata, expQ.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial
    begin
        #100000;
        err_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(48070));
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        rd(OFS_MASK_REMOVABLE, 32'h0);
        rd(OFS_HUB_STATUS, 32'h0);
        rd(8'h54, 32'h0);
        // Unmapped write must touch nothing
        wr(8'h54, 32'hffff_ffff);
        chk("gpwrUnmapped", 32'(globalPowerOn), 32'h0);
        rd(OFS_MASK_REMOVABLE, 32'h0);
        rd(OFS_HUB_STATUS, 32'h0);
        // Random descriptor values, only ports 1 and 2 stored
        repeat (4)
        begin
            rnd = $urandom();
            wr(OFS_MASK_REMOVABLE, rnd);
            rd(OFS_MASK_REMOVABLE, rnd & 32'h0006_0006);
            chk("removableFlags", 32'(removableFlags), 32'(rnd[2:1]));
            perPortMode = 1'b1;
            cyc(1);
            chk("maskPerPort", 32'(portPowerMask), 32'(rnd[18:17]));
            perPortMode = 1'b0;
            cyc(1);
            chk("maskGlobal", 32'(portPowerMask), 32'h0);
        end
        // Global power commands, port 1 masked
        wr(OFS_MASK_REMOVABLE, 32'h0002_0000);
        wr(OFS_HUB_STATUS, 32'h0001_0000);
        chk("gpwrSetGlobal", 32'(globalPowerOn), 32'h3);
        rd(OFS_HUB_STATUS, 32'h0);
        perPortMode = 1'b1;
        wr(OFS_HUB_STATUS, 32'h0000_0001);
        chk("gpwrClrPerPort", 32'(globalPowerOn), 32'h1);
        perPortMode = 1'b0;
        wr(OFS_HUB_STATUS, 32'h0000_0001);
        chk("gpwrClrGlobal", 32'(globalPowerOn), 32'h0);
        perPortMode = 1'b1;
        wr(OFS_HUB_STATUS, 32'h0001_0000);
        chk("gpwrSetPerPort", 32'(globalPowerOn), 32'h2);
        wr(OFS_HUB_STATUS, 32'h0);
        chk("gpwrZeroWrite", 32'(globalPowerOn), 32'h2);
        // Wake enable and resume
        suspended = 1'b1;
        connectChange = 1'b1;
        cyc(1);
        connectChange = 1'b0;
        chk("resumeOff", 32'(resumeEvent), 32'h0);
        wr(OFS_HUB_STATUS, 32'h0000_8000);
        rd(OFS_HUB_STATUS, 32'h0000_8000);
        connectChange = 1'b1;
        cyc(1);
        connectChange = 1'b0;
        chk("resumeOn", 32'(resumeEvent), 32'h1);
        cyc(1);
        chk("resumePulse", 32'(resumeEvent), 32'h0);
        // Awake hub: connect change is no resume
        suspended = 1'b0;
        connectChange = 1'b1;
        cyc(1);
        connectChange = 1'b0;
        chk("resumeAwake", 32'(resumeEvent), 32'h0);
        wr(OFS_HUB_STATUS, 32'h0);
        rd(OFS_HUB_STATUS, 32'h0000_8000);
        wr(OFS_HUB_STATUS, 32'h8000_0000);
        rd(OFS_HUB_STATUS, 32'h0);
        // Overcurrent change flag
        overcurrent = 1'b1;
        cyc(3);
        rd(OFS_HUB_STATUS, 32'h0002_0002);
        wr(OFS_HUB_STATUS, 32'h0);
        rd(OFS_HUB_STATUS, 32'h0002_0002);
        wr(OFS_HUB_STATUS, 32'h0002_0000);
        rd(OFS_HUB_STATUS, 32'h0000_0002);
        overcurrent = 1'b0;
        cyc(3);
        rd(OFS_HUB_STATUS, 32'h0002_0000);
        // Mid-run reset with state set: everything back to zero
        wr(OFS_HUB_STATUS, 32'h0000_8000);
        arst_n = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        chk("gpwrReset", 32'(globalPowerOn), 32'h0);
        rd(OFS_HUB_STATUS, 32'h0);
        rd(OFS_MASK_REMOVABLE, 32'h0);
        cyc(3);
        chk("queueEmpty", 32'(expQ.size()), 32'h0);
        wrap_up();
    end

endmodule

`default_nettype wire
